// ===== rtl/wat_core.sv
// wake-up alarm timer core: seconds counter, alarm compare and pin reset
//
// Summary of operation
// - after timer reset pin rises, counter counts up from zero
// - interrupt goes high when counter equals the stored alarm value
// - on match the counter stops and holds the matched value
// - while the reset pin is low the counter stays cleared
// - reset pin returning high clears interrupt and restarts counting from zero
// - alarm write while counting clears the counter and restarts it
// - with no alarm written since start, interrupt never asserts
// - with no alarm written, counter halts at all ones, no wrap
// - live counter value is readable at any time as elapsed count
// - counter advances once per elapsed second
// - elapsed count is 24 bits, presented as three bytes
// - reset pin is debounced and its filtered level starts high after reset
`timescale 1ns/1ps
module wat_core
  import wat_pkg::*;
#(
  parameter int unsigned TICK_CYC = WAT_TICK_CYC
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // timer reset pin, active low
  input wire logic timer_rst_n_in,
  // alarm byte writes, msb byte first
  input wire logic alarm_wr_in,
  input wire logic [WAT_BYTE_W-1:0] alarm_byte_in,
  // byte read of elapsed count or alarm value
  input wire logic [WAT_BYTE_IDX_W-1:0] rd_idx_in,
  input wire logic rd_alarm_in,
  output logic [WAT_BYTE_W-1:0] rd_byte_out,
  // status
  output logic [WAT_CNT_W-1:0] elapsed_count_out,
  output logic [WAT_CNT_W-1:0] alarm_value_out,
  output logic running_out,
  output logic irq_out
);
  typedef struct packed {
    wat_state_t state;
    logic [31:0] tick_cnt;
    logic [WAT_CNT_W-1:0] count;
    logic [WAT_CNT_W-1:0] alarm;
    logic [WAT_CNT_W-1:0] shadow;
    logic [WAT_BYTE_IDX_W-1:0] wr_idx;
    logic armed;
    logic pin_prev;
    logic irq;
    logic [WAT_BYTE_W-1:0] rd_byte;
  } wat_core_t;

  wat_core_t st_q;
  wat_core_t st_d;
  logic pin_lvl;
  logic tick;
  logic wr_done;

  // select one byte of a 24-bit word, msb byte at index 0
  function automatic logic [WAT_BYTE_W-1:0] wat_byte_sel(
    input logic [WAT_CNT_W-1:0] w,
    input logic [WAT_BYTE_IDX_W-1:0] idx
  );
    logic [WAT_BYTE_W-1:0] b;
    case (idx)
      2'h0: b = w[WAT_MSB_BYTE_LSB +: WAT_BYTE_W];
      2'h1: b = w[WAT_MID_BYTE_LSB +: WAT_BYTE_W];
      2'h2: b = w[WAT_LSB_BYTE_LSB +: WAT_BYTE_W];
      default: b = 8'hff;
    endcase
    return b;
  endfunction

  // ==========================================
  // reset pin filter
  wat_debounce u_deb (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .pin_in(timer_rst_n_in),
    .level_out(pin_lvl)
  );

  assign tick = (st_q.tick_cnt == 32'(TICK_CYC - 1));
  assign wr_done = alarm_wr_in && (st_q.wr_idx == WAT_BYTE_IDX_LAST);

  // ==========================================
  // next state
  always_comb begin
    st_d = st_q;
    st_d.pin_prev = pin_lvl;
    st_d.rd_byte = wat_byte_sel(rd_alarm_in && pin_lvl ? st_q.alarm : st_q.count,
                                rd_idx_in);
    if (alarm_wr_in) begin
      st_d.shadow = {st_q.shadow[WAT_CNT_W-WAT_BYTE_W-1:0], alarm_byte_in};
      st_d.wr_idx = wr_done ? WAT_BYTE_IDX_RST : st_q.wr_idx + 1'b1;
    end
    st_d.tick_cnt = tick ? 32'h0 : st_q.tick_cnt + 32'h1;
    case (st_q.state)
      WAT_IDLE: begin
        if (pin_lvl) begin
          st_d.state = WAT_RUN;
        end
      end
      WAT_RUN: begin
        if (tick) begin
          if (st_q.count == WAT_CNT_MAX) begin
            st_d.state = WAT_SAT;
          end else begin
            st_d.count = st_q.count + 1'b1;
          end
        end
        if (st_q.armed && st_q.count == st_q.alarm) begin
          st_d.state = WAT_MATCH;
          st_d.count = st_q.count;
          st_d.irq = 1'b1;
        end else if (!st_q.armed && st_q.count == WAT_CNT_MAX) begin
          st_d.state = WAT_SAT;
          st_d.count = WAT_CNT_MAX;
        end
      end
      WAT_MATCH: st_d.state = WAT_MATCH;
      WAT_SAT: st_d.state = WAT_SAT;
      default: st_d.state = WAT_IDLE;
    endcase
    if (wr_done) begin
      st_d.alarm = {st_q.shadow[WAT_CNT_W-WAT_BYTE_W-1:0], alarm_byte_in};
      st_d.armed = 1'b1;
      st_d.irq = 1'b0;
      st_d.count = WAT_CNT_RST;
      st_d.tick_cnt = 32'h0;
      st_d.state = pin_lvl ? WAT_RUN : WAT_IDLE;
    end
    if (!pin_lvl) begin
      st_d.count = WAT_CNT_RST;
      st_d.tick_cnt = 32'h0;
      st_d.state = WAT_IDLE;
    end else if (!st_q.pin_prev) begin
      st_d.irq = 1'b0;
      st_d.count = WAT_CNT_RST;
      st_d.tick_cnt = 32'h0;
      st_d.state = WAT_RUN;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= '{state: WAT_IDLE, tick_cnt: 32'h0, count: WAT_CNT_RST,
                alarm: WAT_ALARM_RST, shadow: WAT_CNT_RST, wr_idx: WAT_BYTE_IDX_RST,
                armed: 1'b0, pin_prev: 1'b1, irq: 1'b0, rd_byte: 8'h00};
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_byte_out = st_q.rd_byte;
  assign elapsed_count_out = st_q.count;
  assign alarm_value_out = st_q.alarm;
  assign running_out = (st_q.state == WAT_RUN);
  assign irq_out = st_q.irq;

  // ==========================================
  // assertions
  idle_clear_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !pin_lvl |=> st_q.count == WAT_CNT_RST && !running_out)
    else $error("counter not cleared while reset pin low");
  idle_quiet_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !pin_lvl && !running_out && !wr_done |=> $stable(irq_out))
    else $error("interrupt changed while reset pin low");
  start_run_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    st_q.state == WAT_IDLE && pin_lvl |=> running_out && st_q.count == WAT_CNT_RST)
    else $error("counter did not start from zero");
  rise_restart_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    pin_lvl && !st_q.pin_prev |=> !irq_out && st_q.count == WAT_CNT_RST && running_out)
    else $error("reset release did not restart");
  match_irq_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    running_out && st_q.armed && st_q.count == st_q.alarm && pin_lvl && st_q.pin_prev
    && !alarm_wr_in |=> irq_out)
    else $error("match did not raise interrupt");
  hold_count_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    irq_out && pin_lvl && !alarm_wr_in |=> $stable(st_q.count))
    else $error("counter moved after match");
  no_alarm_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !st_q.armed |-> !irq_out)
    else $error("interrupt without alarm value");
  saturate_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    st_q.count == WAT_CNT_MAX && pin_lvl && st_q.pin_prev && !alarm_wr_in
    |=> st_q.count == WAT_CNT_MAX)
    else $error("counter wrapped");
  write_restart_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_done |=> st_q.count == WAT_CNT_RST && !irq_out)
    else $error("alarm write did not restart");
  step_one_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    running_out && !tick && pin_lvl && st_q.pin_prev && !alarm_wr_in
    |=> st_q.count == $past(st_q.count))
    else $error("counter stepped without tick");
  read_msb_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_idx_in == 2'h0 && !rd_alarm_in |=> rd_byte_out == $past(st_q.count[23:16]))
    else $error("msb byte read wrong");
  tick_step_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    running_out && tick && pin_lvl && st_q.pin_prev && !alarm_wr_in
    && st_q.count != WAT_CNT_MAX && !(st_q.armed && st_q.count == st_q.alarm)
    |=> st_q.count == $past(st_q.count) + 24'h000001)
    else $error("counter did not step on tick");
  partial_hold_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    alarm_wr_in && !wr_done |=> $stable(alarm_value_out))
    else $error("alarm changed before third byte");
  alarm_lsb_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_done |=> alarm_value_out[7:0] == $past(alarm_byte_in))
    else $error("last alarm byte not loaded");
  read_alarm_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_alarm_in && pin_lvl && rd_idx_in == 2'h2 |=> rd_byte_out == $past(st_q.alarm[7:0]))
    else $error("alarm lsb byte read wrong");
  read_pin_low_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_alarm_in && !pin_lvl && rd_idx_in == 2'h2 |=> rd_byte_out == $past(st_q.count[7:0]))
    else $error("count not read while reset pin low");
  read_pad_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_idx_in == 2'h3 |=> rd_byte_out == 8'hff)
    else $error("byte past the third not ones");
  match_seen_c: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) $rose(irq_out));
  write_seen_c: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) wr_done);
  pin_low_c: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) $fell(pin_lvl));
  pin_rise_c: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
    pin_lvl && !st_q.pin_prev);
  partial_seen_c: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
    alarm_wr_in && !wr_done);
endmodule

// ===== rtl/wat_debounce.sv
// three-flop synchroniser and debounce filter for the reset pin
`timescale 1ns/1ps
module wat_debounce
  import wat_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // raw pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [WAT_DEB_W-1:0] cnt;
    logic level;
  } wat_deb_t;

  wat_deb_t st_q;
  wat_deb_t st_d;

  // ==========================================
  // filter: level follows after a stable run of agreeing samples
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if ((st_q.s2 == st_q.s3) && (st_q.s3 != st_q.level)) begin
      if (st_q.cnt == WAT_DEB_W'(WAT_DEB_CYC - 1)) begin
        st_d.level = st_q.s3;
        st_d.cnt = WAT_DEB_RST;
      end else begin
        st_d.cnt = st_q.cnt + 1'b1;
      end
    end else begin
      st_d.cnt = WAT_DEB_RST;
    end
  end

  // pin is pulled high: filtered level starts high
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, cnt: WAT_DEB_RST, level: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.level;
endmodule

// ===== rtl/wat_pkg.sv
// package of constants and types for the wake-up alarm timer core
package wat_pkg;
  // ==========================================
  // widths
  localparam int unsigned WAT_CNT_W = 24;
  localparam int unsigned WAT_BYTE_W = 8;
  localparam int unsigned WAT_NUM_BYTES = 3;
  localparam int unsigned WAT_BYTE_IDX_W = 2;
  // ==========================================
  // reset values and limits
  localparam logic [WAT_CNT_W-1:0] WAT_CNT_RST = 24'h000000;
  localparam logic [WAT_CNT_W-1:0] WAT_CNT_MAX = 24'hffffff;
  localparam logic [WAT_CNT_W-1:0] WAT_ALARM_RST = 24'hffffff;
  localparam logic [WAT_BYTE_IDX_W-1:0] WAT_BYTE_IDX_RST = 2'h0;
  localparam logic [WAT_BYTE_IDX_W-1:0] WAT_BYTE_IDX_LAST = 2'h2;
  // ==========================================
  // field positions of the three byte lanes, msb byte first
  localparam int unsigned WAT_MSB_BYTE_LSB = 16;
  localparam int unsigned WAT_MID_BYTE_LSB = 8;
  localparam int unsigned WAT_LSB_BYTE_LSB = 0;
  // ==========================================
  // timing
  localparam int unsigned WAT_CLK_HZ = 40000000;
  localparam int unsigned WAT_TICK_S = 1;
  localparam int unsigned WAT_TICK_CYC = WAT_CLK_HZ * WAT_TICK_S;
  localparam int unsigned WAT_DEB_NS = 1000;
  localparam int unsigned WAT_CLK_NS = 25;
  localparam int unsigned WAT_DEB_CYC = (WAT_DEB_NS + WAT_CLK_NS - 1) / WAT_CLK_NS;
  localparam int unsigned WAT_DEB_W = 6;
  localparam logic [WAT_DEB_W-1:0] WAT_DEB_RST = 6'h00;
  // ==========================================
  // run states
  typedef enum logic [1:0] {
    WAT_IDLE,
    WAT_RUN,
    WAT_MATCH,
    WAT_SAT
  } wat_state_t;
endpackage

// ===== tb/testbench.sv
// self-checking bench for the wake-up alarm timer core
`timescale 1ns/1ps
module testbench;
  import wat_pkg::*;
  localparam int unsigned TICK = 4;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic pulse_req = 1'b0;
  logic timer_rst_n;
  logic alarm_wr_in = 1'b0;
  logic [WAT_BYTE_W-1:0] alarm_byte_in = 8'h00;
  logic [WAT_BYTE_IDX_W-1:0] rd_idx_in = 2'h0;
  logic rd_alarm_in = 1'b0;
  logic [WAT_BYTE_W-1:0] rd_byte_out;
  logic [WAT_CNT_W-1:0] elapsed_count_out;
  logic [WAT_CNT_W-1:0] alarm_value_out;
  logic running_out;
  logic irq_out;
  int fail_count = 0;
  int checked = 0;
  logic [31:0] rng = 32'h0000005f;
  logic [23:0] v;
  logic [23:0] p;
  // ==========================================
  // design and host
  wat_core #(.TICK_CYC(TICK)) uut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .timer_rst_n_in(timer_rst_n), .alarm_wr_in(alarm_wr_in), .alarm_byte_in(alarm_byte_in),
    .rd_idx_in(rd_idx_in), .rd_alarm_in(rd_alarm_in), .rd_byte_out(rd_byte_out),
    .elapsed_count_out(elapsed_count_out), .alarm_value_out(alarm_value_out),
    .running_out(running_out), .irq_out(irq_out));
  wat_host_model host (.sys_clk_in(sys_clk_in), .pulse_req_in(pulse_req),
    .timer_rst_n_out(timer_rst_n));
  initial forever #12.5 sys_clk_in = ~sys_clk_in;
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [7:0] exp_byte(input logic [23:0] w, input int i);
    return (i == 3) ? 8'hff : w[23-8*i -: 8];
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  task automatic wr_alarm(input logic [23:0] w, input int s, input int e);
    for (int i = s; i < e; i++) begin
      @(negedge sys_clk_in);
      alarm_wr_in = 1'b1;
      alarm_byte_in = w[23-8*i -: 8];
    end
    @(negedge sys_clk_in);
    alarm_wr_in = 1'b0;
  endtask
  task automatic rd_chk(input logic sel, input logic [23:0] w);
    for (int i = 0; i < 4; i++) begin
      rd_alarm_in = sel;
      rd_idx_in = 2'(i);
      cyc(1);
      chk({16'h0, rd_byte_out}, {16'h0, exp_byte(w, i)}, "read byte");
    end
    rd_alarm_in = 1'b0;
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq_out !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      $display("unexpected at %0t: no interrupt", $time);
      conclude();
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    cyc(20);
    chk(elapsed_count_out, 24'h000000, "count in reset");
    chk(alarm_value_out, WAT_ALARM_RST, "alarm in reset");
    nrst_in = 1'b1;
    cyc(40);
    chk({23'h0, elapsed_count_out >= 24'h9 && elapsed_count_out <= 24'hb}, 24'h1, "rate");
    chk({23'h0, irq_out}, 24'h0, "unarmed irq");
    rng = xs(rng);
    v = rng[23:0];
    wr_alarm(v, 0, 3);
    chk(alarm_value_out, v, "wide alarm");
    rd_chk(1'b1, v);
    for (int k = 0; k < 4; k++) begin
      rng = xs(rng);
      p = v;
      v = (k == 1) ? 24'h000001 : {19'h0, rng[4:0]} + 24'h2;
      wr_alarm(v, 0, (k == 0) ? 2 : 3);
      if (k == 0) begin
        chk(alarm_value_out, p, "partial");
        wr_alarm(v, 2, 3);
      end
      chk(elapsed_count_out, 24'h000000, "restart on write");
      chk({23'h0, irq_out}, 24'h0, "irq cleared by write");
      wait_irq((v + 2) * TICK + 8);
      chk(elapsed_count_out, v, "match value");
      cyc(3 * TICK);
      chk(elapsed_count_out, v, "frozen count");
      rd_chk(1'b0, v);
    end
    pulse_req = 1'b1;
    cyc(1);
    pulse_req = 1'b0;
    cyc(55);
    chk(elapsed_count_out, 24'h000000, "pin low");
    chk({22'h0, irq_out, running_out}, 24'h000002, "irq held while pin low");
    rd_chk(1'b1, 24'h000000);
    cyc(46);
    chk({23'h0, irq_out}, 24'h0, "irq low after pin");
    chk({23'h0, running_out}, 24'h1, "running after pin");
    chk(elapsed_count_out, 24'h000000, "count from zero");
    wait_irq((v + 2) * TICK + 8);
    chk(elapsed_count_out, v, "match after pin");
    nrst_in = 1'b0;
    cyc(2);
    nrst_in = 1'b1;
    cyc(300);
    chk({23'h0, irq_out}, 24'h0, "no alarm no irq");
    chk(alarm_value_out, WAT_ALARM_RST, "alarm after reset");
    chk(elapsed_count_out, 24'(300 / TICK), "count after reset");
    conclude();
  end
endmodule

// ===== tb/wat_host_model.sv
// host model that drives the timer reset pin
`timescale 1ns/1ps
module wat_host_model #(
  parameter int unsigned LOW_CYC = 60
) (
  // clock
  input wire logic sys_clk_in,
  // pulse request from the bench
  input wire logic pulse_req_in,
  // timer reset pin
  output logic timer_rst_n_out
);
  int unsigned low_left = 0;
  // ==========================================
  // pin idles high as if pulled up
  initial timer_rst_n_out = 1'b1;
  // low then high pulse restarts the timer
  always @(posedge sys_clk_in) begin
    if (pulse_req_in) begin
      low_left <= LOW_CYC;
      timer_rst_n_out <= 1'b0;
    end else if (low_left > 1) begin
      low_left <= low_left - 1;
    end else if (low_left == 1) begin
      low_left <= 0;
      timer_rst_n_out <= 1'b1;
    end
  end
endmodule
